// >>> common/epr_pkg.sv
// Purpose: Shared constants and carriers for the exception priority router.
// Assumes: One bus clock; 16-bit register data; 8-bit word register address.
// Notes:   Channel index is the vector offset divided by two.
package epr_pkg;

   // Register map, one word per address.
   localparam logic [7:0]  CFG_LAST_ADDR  = 8'h7F;
   localparam logic [7:0]  VBASE_ADDR     = 8'h80;
   localparam logic [7:0]  CO_PRIO_ADDR   = 8'h81;
   localparam logic [7:0]  CTRL_ADDR      = 8'h82;
   localparam logic [7:0]  STATUS_ADDR    = 8'h83;

   // Channel layout and configuration fields.
   localparam int          NUM_CHAN       = 128;
   localparam logic [6:0]  SPUR_IDX       = 7'h08;
   localparam logic [6:0]  FIRST_CFG_IDX  = 7'h0D;
   localparam logic [6:0]  PIN_IRQ_IDX    = 7'h79;
   localparam int          CFG_TGT_BIT    = 3;
   localparam logic [2:0]  CFG_RST_PRIO   = 3'h1;
   localparam logic [15:0] SPUR_CFG_READ  = 16'h0007;
   localparam logic [2:0]  PRIO_OFF       = 3'h0;

   // Reset values of the remaining registers.
   localparam logic [7:0]  VBASE_RST      = 8'hFF;
   localparam logic [2:0]  CO_PRIO_RST    = 3'h1;

   // Fixed vectors and vector offsets.
   localparam logic [15:0] VEC_RST_PIN    = 16'hFFFE;
   localparam logic [15:0] VEC_CLK_MON    = 16'hFFFC;
   localparam logic [15:0] VEC_WATCHDOG   = 16'hFFFA;
   localparam logic [7:0]  OFS_TRAP       = 8'hF8;
   localparam logic [7:0]  OFS_SWI        = 8'hF6;
   localparam logic [7:0]  OFS_SYSCALL    = 8'h12;
   localparam logic [7:0]  OFS_CO_AV      = 8'h16;
   localparam logic [7:0]  OFS_CPU_AV     = 8'h14;
   localparam logic [7:0]  OFS_NMI_PIN    = 8'hF4;
   localparam logic [7:0]  OFS_SPURIOUS   = 8'h10;

   // Non-maskable exception requests from the core and the reset unit.
   typedef struct packed {
      logic rst_pin;
      logic clk_mon;
      logic watchdog_reset;
      logic trap;
      logic software_interrupt;
      logic system_call_request;
      logic coproc_av;
      logic cpu_av;
      logic nonmaskable_pin_request;
   } epr_exc_s;

   // Vector answer to the CPU.
   typedef struct packed {
      logic        valid;
      logic [15:0] vector;
      logic [2:0]  new_level;
   } epr_vec_s;

   // Request handed to the co-processor.
   typedef struct packed {
      logic       valid;
      logic [6:0] chan;
      logic       high_prio;
   } epr_co_s;

   // Whole state of the router.
   typedef struct packed {
      logic [127:0][3:0] cfg;
      logic [7:0]        vbase;
      logic [2:0]        co_prio;
      logic              gie;
      logic [15:0]       rdata;
      logic              cpu_irq;
      logic              cpu_nmi;
      epr_vec_s          vec;
      epr_co_s           co;
   } epr_state_s;

endpackage

// >>> rtl/epr_exception_router.sv
// Purpose: Prioritises exception and interrupt requests for the CPU and the co-processor.
// Assumes: All requests come from logic on sys_clk; the CPU supplies its level and mask bit.
// Notes:   Outputs are registered, so they follow their inputs by one clock.
//
// How it works
// [R1] After reset channels up to offset F2 are enabled, CPU-routed, level 1.
// [R2] Non-maskable and spurious vectors cannot be disabled, go to CPU, fixed order.
// [R3] Priority zero disables a maskable channel for both targets.
// [R4] Equal levels: the channel with the higher vector address wins.
// [R5] CPU maskable request needs CPU target, level above current, mask clear, no exception.
// [R6] Peripherals raise a channel only with their local enable set.
// [R7] Non-maskable exceptions outrank maskable ones and leave the level unchanged.
// [R8] On vector fetch the new level is the winning CPU channel priority.
// [R9] The level lives in the condition code register, stacked and restored there.
// [R10] Target bit one routes a channel to the co-processor with its priority.
// [R11] Co-processor flags raise a CPU interrupt at base plus twice the channel.
// [R12] Co-processor raised interrupts share one priority; higher vector wins.
// [R13] Two independent decoders serve CPU and co-processor with the same arbitration.
// [R14] Co-processor decoder ignores thread level and passes the priority MSB.
// [R15] A vector is given only on request, that of the current winner.
// [R16] With no qualifying source the spurious vector is supplied.
// [R17] Sources hold requests until their service routine starts.
// [R18] Reset vectors FFFE, FFFC, FFFA in descending priority.
// [R19] Then trap, software interrupt, system call, reserved, access violations, pin NMI.
// [R20] Then maskable pin request, configurable channels by level, spurious last.
// [R21] Access violation requests exist only with the protection unit; co-processor ones also need the co-processor.
// [R22] Vectors are 16-bit: base byte and offset.
// [R23] Priority field: zero disabled, one to seven, seven highest.
// [R24] Target bit zero CPU, one co-processor; maskable pin request always CPU.
// [R25] Interrupt request output falls within one clock when nothing qualifies.
// [R26] Decoders evaluate all channels combinationally every clock.
`timescale 1ns/100ps
module epr_exception_router #(
   parameter bit HAS_MPU    = 1'b1,
   parameter bit HAS_COPROC = 1'b1
) (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output      logic [15:0]           reg_rdata,
   input  wire logic [127:0]          chan_req,
   input  wire logic [127:0]          coproc_flags,
   input  wire epr_pkg::epr_exc_s     exc_req,
   input  wire logic [2:0]            processing_level,
   input  wire logic                  cpu_mask_bit,
   input  wire logic                  cpu_vec_req,
   output      logic                  cpu_irq,
   output      logic                  cpu_nmi,
   output      epr_pkg::epr_vec_s     cpu_vec,
   output      epr_pkg::epr_co_s      coproc_req
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Arbitration helper, shared by both decoders.

   // Returns {level, index}; ties go to the higher index, level zero means no winner.
   function automatic logic [9:0] epr_pick(input logic [127:0][2:0] lvl);
      logic [2:0] best;
      logic [6:0] idx;
      best = epr_pkg::PRIO_OFF;
      idx  = 7'h00;
      for (int i = 0; i < epr_pkg::NUM_CHAN; i++) begin
         if (lvl[i] != epr_pkg::PRIO_OFF && lvl[i] >= best) begin // [R4] [R23]
            best = lvl[i];
            idx  = 7'(i);
         end
      end
      return {best, idx};
   endfunction

   // True for indices that carry a configuration register.
   function automatic logic epr_has_cfg(input logic [6:0] idx);
      return idx >= epr_pkg::FIRST_CFG_IDX && idx <= epr_pkg::PIN_IRQ_IDX;
   endfunction

   epr_pkg::epr_state_s st;
   epr_pkg::epr_state_s next_st;

   logic [127:0][2:0] cpu_lvl;
   logic [127:0][2:0] co_lvl;
   logic [9:0]        cpu_pick;
   logic [9:0]        co_pick;
   logic              exc_any;
   logic              cpu_qual;
   logic              co_av_live;
   logic              cpu_av_live;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Per-channel candidate levels for both targets.

   for (genvar g = 0; g < epr_pkg::NUM_CHAN; g++) begin : g_chan
      always_comb begin
         cpu_lvl[g] = epr_pkg::PRIO_OFF;
         co_lvl[g]  = epr_pkg::PRIO_OFF;
         if (epr_has_cfg(7'(g))) begin
            if (!st.cfg[g][epr_pkg::CFG_TGT_BIT] || 7'(g) == epr_pkg::PIN_IRQ_IDX) begin
               if (chan_req[g]) begin
                  cpu_lvl[g] = st.cfg[g][2:0]; // [R5] [R24] [R3]
               end
            end else begin
               if (HAS_COPROC && chan_req[g]) begin
                  co_lvl[g] = st.cfg[g][2:0]; // [R10] [R3]
               end
               if (HAS_COPROC && coproc_flags[g] && st.gie) begin
                  cpu_lvl[g] = st.co_prio; // [R11] [R12]
               end
            end
         end
      end
   end

   // Both decoders look at the live requests and configuration each clock.
   assign cpu_pick = epr_pick(cpu_lvl); // [R13] [R26]
   assign co_pick  = epr_pick(co_lvl); // [R13] [R26]

   assign co_av_live  = HAS_MPU && HAS_COPROC && exc_req.coproc_av; // [R21]
   assign cpu_av_live = HAS_MPU && exc_req.cpu_av; // [R21]

   // Any non-maskable request blocks maskable service.
   assign exc_any = exc_req.rst_pin || exc_req.clk_mon || exc_req.watchdog_reset || exc_req.trap
                 || exc_req.software_interrupt || exc_req.system_call_request || co_av_live
                 || cpu_av_live || exc_req.nonmaskable_pin_request; // [R7]

   // Level is the caller's condition code register field, so nesting is undone by stacking.
   assign cpu_qual = cpu_pick[9:7] > processing_level && !cpu_mask_bit && !exc_any; // [R5] [R9]

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      logic [15:0] base;
      base    = {st.vbase, 8'h00};
      next_st = st;

      // Register writes; unconfigurable slots ignore them.
      if (reg_wr) begin
         if (reg_addr <= epr_pkg::CFG_LAST_ADDR) begin
            if (epr_has_cfg(reg_addr[6:0])) begin
               next_st.cfg[reg_addr[6:0]] = reg_wdata[3:0];
               if (reg_addr[6:0] == epr_pkg::PIN_IRQ_IDX || !HAS_COPROC) begin
                  next_st.cfg[reg_addr[6:0]][epr_pkg::CFG_TGT_BIT] = 1'b0; // [R24]
               end
            end
         end else if (reg_addr == epr_pkg::VBASE_ADDR) begin
            next_st.vbase = reg_wdata[15:8];
         end else if (reg_addr == epr_pkg::CO_PRIO_ADDR) begin
            next_st.co_prio = reg_wdata[2:0];
         end else if (reg_addr == epr_pkg::CTRL_ADDR) begin
            next_st.gie = reg_wdata[0];
         end
      end

      // Register reads, answered in the next cycle; unmapped reads give zero.
      next_st.rdata = 16'h0000;
      if (reg_rd) begin
         if (reg_addr <= epr_pkg::CFG_LAST_ADDR) begin
            if (reg_addr[6:0] == epr_pkg::SPUR_IDX) begin
               next_st.rdata = epr_pkg::SPUR_CFG_READ; // [R2]
            end else if (epr_has_cfg(reg_addr[6:0])) begin
               next_st.rdata = {12'h000, st.cfg[reg_addr[6:0]]};
            end
         end else if (reg_addr == epr_pkg::VBASE_ADDR) begin
            next_st.rdata = {st.vbase, 8'h00};
         end else if (reg_addr == epr_pkg::CO_PRIO_ADDR) begin
            next_st.rdata = {13'h0000, st.co_prio};
         end else if (reg_addr == epr_pkg::CTRL_ADDR) begin
            next_st.rdata = {15'h0000, st.gie};
         end else if (reg_addr == epr_pkg::STATUS_ADDR) begin
            next_st.rdata = {st.cpu_irq, st.cpu_nmi, st.co.valid, st.co.high_prio,
                             1'b0, cpu_pick[9:7], 1'b0, cpu_pick[6:0]};
         end
      end

      // Request outputs drop in the next clock once nothing qualifies.
      next_st.cpu_irq = cpu_qual; // [R5] [R25]
      next_st.cpu_nmi = exc_any; // [R2] [R7]

      // Co-processor decoder ignores thread level and hands on the priority MSB.
      next_st.co.valid     = co_pick[9:7] != epr_pkg::PRIO_OFF; // [R25]
      next_st.co.chan      = co_pick[6:0];
      next_st.co.high_prio = co_pick[9]; // [R14]

      // Vector supplied only when asked, from whatever wins at that moment.
      next_st.vec.valid = cpu_vec_req; // [R15]
      if (cpu_vec_req) begin
         next_st.vec.new_level = processing_level; // [R7]
         if (exc_req.rst_pin) begin
            next_st.vec.vector = epr_pkg::VEC_RST_PIN; // [R18]
         end else if (exc_req.clk_mon) begin
            next_st.vec.vector = epr_pkg::VEC_CLK_MON; // [R18]
         end else if (exc_req.watchdog_reset) begin
            next_st.vec.vector = epr_pkg::VEC_WATCHDOG; // [R18]
         end else if (exc_req.trap) begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_TRAP}; // [R19] [R22]
         end else if (exc_req.software_interrupt) begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_SWI}; // [R19]
         end else if (exc_req.system_call_request) begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_SYSCALL}; // [R19]
         end else if (co_av_live) begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_CO_AV}; // [R19]
         end else if (cpu_av_live) begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_CPU_AV}; // [R19]
         end else if (exc_req.nonmaskable_pin_request) begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_NMI_PIN}; // [R19]
         end else if (cpu_pick[9:7] > processing_level && !cpu_mask_bit) begin
            next_st.vec.vector    = base | {8'h00, cpu_pick[6:0], 1'b0}; // [R20] [R22]
            next_st.vec.new_level = cpu_pick[9:7]; // [R8]
         end else begin
            next_st.vec.vector = base | {8'h00, epr_pkg::OFS_SPURIOUS}; // [R16] [R20]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         for (int i = 0; i < epr_pkg::NUM_CHAN; i++) begin
            if (i >= int'(epr_pkg::FIRST_CFG_IDX) && i <= int'(epr_pkg::PIN_IRQ_IDX)) begin
               st.cfg[i] <= {1'b0, epr_pkg::CFG_RST_PRIO}; // [R1]
            end
         end
         st.vbase   <= epr_pkg::VBASE_RST;
         st.co_prio <= epr_pkg::CO_PRIO_RST;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata  = st.rdata;
   assign cpu_irq    = st.cpu_irq;
   assign cpu_nmi    = st.cpu_nmi;
   assign cpu_vec    = st.vec;
   assign coproc_req = st.co;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_irq_raise: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
      cpu_qual |=> cpu_irq) else $error("CPU request not raised when qualified.");

   a_irq_drop: assert property (@(posedge sys_clk) disable iff (!resetn) // [R25]
      !cpu_qual |=> !cpu_irq) else $error("CPU request kept without a qualifying source.");

   a_mask_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
      (cpu_mask_bit || exc_any) |=> !cpu_irq) else $error("Masked request reached the CPU.");

   a_reset_vec: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18]
      (cpu_vec_req && exc_req.rst_pin) |=> (cpu_vec.valid && cpu_vec.vector == 16'hFFFE))
      else $error("Pin reset vector wrong.");

   a_nmi_level: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
      (cpu_vec_req && exc_any) |=> cpu_vec.new_level == $past(processing_level))
      else $error("Exception changed the processing level.");

   a_fetch_level: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
      (cpu_vec_req && cpu_qual) |=> (cpu_vec.new_level == $past(cpu_pick[9:7])
      && cpu_vec.vector[7:0] == {$past(cpu_pick[6:0]), 1'b0})) else $error("Fetched level wrong.");

   a_spur_vec: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
      (cpu_vec_req && !exc_any && (cpu_mask_bit || cpu_pick[9:7] <= processing_level))
      |=> cpu_vec.vector[7:0] == 8'h10) else $error("Spurious vector not supplied.");

   a_vec_only_req: assert property (@(posedge sys_clk) disable iff (!resetn) // [R15]
      cpu_vec.valid |-> $past(cpu_vec_req)) else $error("Vector given without a request.");

   a_co_msb: assert property (@(posedge sys_clk) disable iff (!resetn) // [R14]
      coproc_req.valid |-> (coproc_req.high_prio == $past(st.cfg[co_pick[6:0]][2])
      && $past(st.cfg[co_pick[6:0]][2:0]) != 3'h0)) else $error("Co-processor priority flag wrong.");

   a_spur_cfg: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2]
      (reg_rd && reg_addr == 8'h08) |=> reg_rdata == 16'h0007) else $error("Spurious config read wrong.");

endmodule // epr_exception_router

// >>> dv/epr_cpu_model.sv
// Purpose: Behavioural CPU core that fetches vectors and keeps the processing level.
// Assumes: The bench asks for a vector through go and reloads the level on return.
// Notes:   The level moves only on a vector fetch or on a bench reload.
`timescale 1ns/100ps
module epr_cpu_model (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              go,
   input  wire logic              lvl_we,
   input  wire logic [2:0]        lvl_in,
   input  wire epr_pkg::epr_vec_s cpu_vec,
   output      logic              cpu_vec_req,
   output      logic [2:0]        processing_level,
   output      logic              got,
   output      logic [15:0]       got_vec
);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cpu_vec_req      <= 1'b0;
         processing_level <= 3'h0;
         got              <= 1'b0;
         got_vec          <= 16'h0000;
      end else begin
         cpu_vec_req <= go;
         got         <= cpu_vec.valid;
         if (cpu_vec.valid) begin
            got_vec          <= cpu_vec.vector;
            processing_level <= cpu_vec.new_level;
         end else if (lvl_we) begin
            processing_level <= lvl_in;
         end
      end
   end
endmodule // epr_cpu_model

// >>> dv/tb_exception_priority_router.sv
// Purpose: Self-checking bench for the exception router.
// Assumes: Requests are held until their vector is fetched.
// Notes:   Inputs change by non-blocking assignment after a rising edge.
`timescale 1ns/100ps
module tb_exception_priority_router;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic [7:0]        reg_addr = 8'h00;
   logic [15:0]       reg_wdata = 16'h0000;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [15:0]       reg_rdata;
   logic [127:0]      chan_req = '0;
   logic [127:0]      coproc_flags = '0;
   epr_pkg::epr_exc_s exc_req = '0;
   logic              cpu_mask_bit = 1'b0;
   logic              go = 1'b0;
   logic              lvl_we = 1'b0;
   logic [2:0]        lvl_in = 3'h0;
   logic [2:0]        processing_level;
   logic              cpu_vec_req;
   logic              cpu_irq;
   logic              cpu_nmi;
   logic              got;
   logic [15:0]       got_vec;
   epr_pkg::epr_vec_s cpu_vec;
   epr_pkg::epr_co_s  coproc_req;
   int                n_errors = 0;
   int                samples_checked = 0;
   logic [15:0]       exc_vec [9] = '{16'hFFF4, 16'hFF14, 16'hFF16, 16'hFF12, 16'hFFF6, 16'hFFF8,
                                      16'hFFFA, 16'hFFFC, 16'hFFFE};
   always #20 sys_clk = ~sys_clk;
   epr_exception_router u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .chan_req(chan_req), .coproc_flags(coproc_flags), .exc_req(exc_req),
      .processing_level(processing_level), .cpu_mask_bit(cpu_mask_bit), .cpu_vec_req(cpu_vec_req),
      .cpu_irq(cpu_irq), .cpu_nmi(cpu_nmi), .cpu_vec(cpu_vec), .coproc_req(coproc_req));
   epr_cpu_model u_cpu (.sys_clk(sys_clk), .resetn(resetn), .go(go), .lvl_we(lvl_we), .lvl_in(lvl_in),
      .cpu_vec(cpu_vec), .cpu_vec_req(cpu_vec_req), .processing_level(processing_level), .got(got),
      .got_vec(got_vec));
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   // Drives the request inputs, then waits until the registered outputs follow.
   task automatic set_in(input logic [127:0] c, input logic [127:0] f, input logic [8:0] e);
      @(posedge sys_clk);
      chan_req     <= c;
      coproc_flags <= f;
      exc_req      <= epr_pkg::epr_exc_s'(e);
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic lvl(input logic [2:0] v);
      @(posedge sys_clk);
      lvl_we <= 1'b1;
      lvl_in <= v;
      @(posedge sys_clk);
      lvl_we <= 1'b0;
   endtask
   task automatic getvec(input logic [15:0] exp);
      int n;
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      n = 0;
      while (got !== 1'b1 && n < 8) begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (n == 8) begin
         n_errors++;
         give_verdict();
      end else begin
         check(got_vec, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(8'h40, 16'h0001);
      rd(8'h79, 16'h0001);
      rd(8'h7A, 16'h0000);
      rd(8'h80, 16'hFF00);
      rd(8'h90, 16'h0000);
      wr(8'h08, 16'h0000);
      rd(8'h08, 16'h0007);
      wr(8'h79, 16'h000E);
      rd(8'h79, 16'h0006);
      $display("test reset_map done");
      wr(8'h40, 16'h0003);
      set_in(128'h1 << 8'h40, '0, 9'h000);
      check({15'h0, cpu_irq}, 16'h0001);
      getvec(16'hFF80);
      check({13'h0, processing_level}, 16'h0003);
      set_in(128'h1 << 8'h40, '0, 9'h000);
      check({15'h0, cpu_irq}, 16'h0000);
      lvl(3'h0);
      @(posedge sys_clk);
      cpu_mask_bit <= 1'b1;
      set_in(128'h1 << 8'h40, '0, 9'h000);
      check({15'h0, cpu_irq}, 16'h0000);
      cpu_mask_bit <= 1'b0;
      $display("test cpu_walk done");
      wr(8'h30, 16'h0002);
      wr(8'h31, 16'h0002);
      set_in(128'h3 << 8'h30, '0, 9'h000);
      getvec(16'hFF62);
      lvl(3'h0);
      set_in((128'h3 << 8'h30) | (128'h1 << 8'h40), '0, 9'h000);
      getvec(16'hFF80);
      lvl(3'h0);
      wr(8'h30, 16'h0000);
      set_in(128'h1 << 8'h30, '0, 9'h000);
      check({15'h0, cpu_irq}, 16'h0000);
      getvec(16'hFF10);
      $display("test arbitration done");
      lvl(3'h2);
      for (int i = 8; i >= 0; i--) begin
         set_in(128'h1 << 8'h40, '0, 9'h1FF >> (8 - i));
         check({14'h0, cpu_irq, cpu_nmi}, 16'h0001);
         getvec(exc_vec[i]);
         check({13'h0, processing_level}, 16'h0002);
      end
      $display("test exceptions done");
      lvl(3'h0);
      wr(8'h20, 16'h000D);
      wr(8'h21, 16'h000B);
      set_in(128'h3 << 8'h20, '0, 9'h000);
      check({7'h0, coproc_req}, {7'h0, 1'b1, 7'h20, 1'b1});
      check({15'h0, cpu_irq}, 16'h0000);
      set_in(128'h1 << 8'h21, '0, 9'h000);
      check({7'h0, coproc_req}, {7'h0, 1'b1, 7'h21, 1'b0});
      rd(8'h83, 16'h2000);
      wr(8'h20, 16'h000B);
      set_in(128'h3 << 8'h20, '0, 9'h000);
      check({7'h0, coproc_req}, {7'h0, 1'b1, 7'h21, 1'b0});
      $display("test coproc_decoder done");
      wr(8'h82, 16'h0001);
      wr(8'h81, 16'h0004);
      rd(8'h82, 16'h0001);
      rd(8'h81, 16'h0004);
      wr(8'h22, 16'h0009);
      set_in('0, 128'h3 << 8'h21, 9'h000);
      check({15'h0, cpu_irq}, 16'h0001);
      getvec(16'hFF44);
      check({13'h0, processing_level}, 16'h0004);
      lvl(3'h0);
      set_in('0, 128'h1 << 8'h40, 9'h000);
      check({15'h0, cpu_irq}, 16'h0000);
      wr(8'h80, 16'h1200);
      set_in(128'h1 << 8'h40, '0, 9'h000);
      getvec(16'h1280);
      $display("test coproc_raise done");
      give_verdict();
   end
endmodule // tb_exception_priority_router
